// >>> src/cal_pkg.sv
package cal_pkg;
	// Clock and timing
	localparam int CLK_HZ = 50_000_000;
	localparam int MCLK_HZ = 7_680_000;
	localparam int LINK_DIV = 8;
	// Calibration times in microseconds at the reference master clock
	localparam int SELF_CAL_3750_US = 1300;
	localparam int SELF_CAL_2000_US = 2000;
	localparam int SYS_GAIN_100_US = 20400;
	localparam int SYS_GAIN_2P5_US = 800400;
	// Timeout in data-ready periods
	localparam int IDLE_DATA_READY_N_PERIODS = 32;
	localparam int DATA_READY_N_PERIOD_CYC = 13_333;
	// System gain acceptance: input at least this percent of full scale
	localparam int GAIN_MIN_PCT = 80;
	// Command codes
	localparam logic [7:0] CMD_SELF_OFFSET = 8'hf1;
	localparam logic [7:0] CMD_SELF_GAIN = 8'hf2;
	localparam logic [7:0] CMD_FULL_SELF = 8'hf0;
	localparam logic [7:0] CMD_SYS_OFFSET = 8'hf3;
	localparam logic [7:0] CMD_SYS_GAIN = 8'hf4;
	localparam logic [7:0] CMD_WRITE_REG = 8'h50;
	localparam logic [7:0] CMD_READ_REG = 8'h10;
	localparam logic [7:0] CMD_CONT_READ = 8'h03;
	// Register indices
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h2;
	localparam logic [3:0] REG_RATE = 4'h3;
	localparam logic [3:0] REG_OFC0 = 4'h5;
	localparam logic [3:0] REG_FSC0 = 4'h8;
	localparam int REG_COUNT = 11;
	// Field positions
	localparam int STATUS_AUTO_CALIBRATION_ENABLE_BIT = 2;
	localparam int STATUS_BUF_BIT = 1;
	localparam logic [2:0] CTRL_GAIN_MASK = 3'h7;
	// Reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h20;
	localparam logic [7:0] RATE_RST = 8'hf0;
	localparam logic [23:0] OFC_RST = 24'h000000;
	localparam logic [23:0] FSC_RST = 24'h400000;
	// Converts microseconds at the master clock to system clock cycles
	function automatic int us_to_cyc(input int us);
		longint c;
		c = longint'(us) * CLK_HZ / 1_000_000;
		return (c < 1) ? 1 : int'(c);
	endfunction
	typedef enum logic [2:0]
	{
		CS_IDLE = 3'b000,
		CS_OFFSET = 3'b001,
		CS_GAIN = 3'b011,
		CS_SETTLE = 3'b010
	} cal_state_t;
endpackage

// >>> src/cal_link_if.sv
interface cal_link_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout_o;
	logic dout_oe;
	logic data_ready_n;
	logic [23:0] ain_diff;
	logic ain_attached;
	modport device (input cs_n, input sclk, input din, output dout_o, output dout_oe,
		output data_ready_n, input ain_diff, output ain_attached);
	modport host (output cs_n, output sclk, output din, input dout_o, input dout_oe,
		input data_ready_n, output ain_diff, input ain_attached);
endinterface

// >>> src/cal_fifo.sv
module cal_fifo
	import cal_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Write side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Read side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire empty = wr_ptr == rd_ptr;
	wire do_wr = in_valid && !full;
	wire do_rd = out_ready && !empty;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// >>> src/cal_device.sv
module cal_device
	import cal_pkg::*;
#(
	parameter int OFFSET_CYC = us_to_cyc(SELF_CAL_2000_US / 2),
	parameter int GAIN_CYC = us_to_cyc(SELF_CAL_2000_US / 2),
	parameter int SETTLE_CYC = 64,
	parameter int IDLE_CYC = IDLE_DATA_READY_N_PERIODS * DATA_READY_N_PERIOD_CYC
)
(
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Link
	cal_link_if.device link,
	// Status
	output logic cal_busy,
	output logic [23:0] offset_out,
	output logic [23:0] gain_out
);
	// Pin synchronisers
	logic [1:0] cs_s, sclk_s, din_s;
	logic sclk_d;
	logic din_d;
	logic [23:0] ain_s1, ain_s2;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cs_s <= 2'h3;
			sclk_s <= 2'h0;
			din_s <= 2'h0;
			sclk_d <= 1'b0;
			din_d <= 1'b0;
			ain_s1 <= 24'h0;
			ain_s2 <= 24'h0;
		end
		else
		begin
			cs_s <= {cs_s[0], link.cs_n};
			sclk_s <= {sclk_s[0], link.sclk};
			din_s <= {din_s[0], link.din};
			sclk_d <= sclk_s[1];
			// Data as it stood before the detected fall
			din_d <= din_s[1];
			ain_s1 <= link.ain_diff;
			ain_s2 <= ain_s1;
		end
	end
	wire cs_hi = cs_s[1];
	wire sclk_rise = sclk_s[1] && !sclk_d;
	wire sclk_fall = !sclk_s[1] && sclk_d;
	// Serial engine
	logic [7:0] regs [REG_COUNT];
	logic [7:0] shreg;
	logic [2:0] bitcnt;
	logic [1:0] phase;
	logic [7:0] cmd;
	logic [3:0] ridx;
	logic [7:0] obyte;
	logic out_en;
	logic [31:0] idle_cnt;
	logic cal_req;
	logic [7:0] cal_cmd;
	wire [7:0] byte_in = {shreg[6:0], din_d};
	wire byte_done = sclk_fall && bitcnt == 3'h7;
	wire idle_to = idle_cnt >= 32'(IDLE_CYC);
	wire port_rst = cs_hi || idle_to;
	wire is_cal = byte_in == CMD_FULL_SELF || byte_in == CMD_SELF_OFFSET || byte_in == CMD_SELF_GAIN
		|| byte_in == CMD_SYS_OFFSET || byte_in == CMD_SYS_GAIN;
	wire is_wr = byte_in[7:4] == CMD_WRITE_REG[7:4];
	wire is_rd = byte_in[7:4] == CMD_READ_REG[7:4];
	wire [3:0] byte_idx = byte_in[3:0];
	wire idx_ok = 32'(ridx) < REG_COUNT;
	wire cfg_hit = ridx == REG_STATUS || ridx == REG_CTRL || ridx == REG_RATE;
	cal_state_t state, next_state;
	logic [31:0] cal_cnt;
	logic self_mode, gain_only, offset_only;
	wire cal_done_tick = cal_cnt == 32'h1;
	// Gain-cal time scales with the CTRL gain field only
	wire [31:0] gain_time = 32'(GAIN_CYC) + {29'h0, regs[REG_CTRL][2:0] & CTRL_GAIN_MASK} * 32'(SETTLE_CYC);
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			shreg <= 8'h0;
			bitcnt <= 3'h0;
			phase <= 2'h0;
			cmd <= 8'h0;
			ridx <= 4'h0;
			obyte <= 8'h0;
			out_en <= 1'b0;
			idle_cnt <= 32'h0;
			cal_req <= 1'b0;
			cal_cmd <= 8'h0;
			for (int i = 0; i < REG_COUNT; i++)
				regs[i] <= 8'h0;
			regs[REG_STATUS] <= STATUS_RST;
			regs[REG_CTRL] <= CTRL_RST;
			regs[REG_RATE] <= RATE_RST;
			{regs[REG_OFC0+2], regs[REG_OFC0+1], regs[REG_OFC0]} <= OFC_RST;
			{regs[REG_FSC0+2], regs[REG_FSC0+1], regs[REG_FSC0]} <= FSC_RST;
		end
		else
		begin
			cal_req <= 1'b0;
			idle_cnt <= (sclk_s[1] || port_rst) ? 32'h0 : idle_cnt + 32'h1;
			if (port_rst)
			begin
				bitcnt <= 3'h0;
				phase <= 2'h0;
				out_en <= 1'b0;
			end
			else
			begin
				if (sclk_rise && phase == 2'h2)
				begin
					out_en <= 1'b1;
					obyte <= (bitcnt == 3'h0) ? regs[ridx] : {obyte[6:0], 1'b0};
				end
				if (sclk_fall)
				begin
					shreg <= byte_in;
					bitcnt <= bitcnt + 3'h1;
				end
				if (byte_done)
				begin
					out_en <= 1'b0;
					unique case (phase)
						2'h0:
						begin
							cmd <= byte_in;
							ridx <= byte_idx;
							if (is_cal)
							begin
								cal_req <= 1'b1;
								cal_cmd <= byte_in;
							end
							phase <= is_wr ? 2'h1 : (is_rd ? 2'h2 : 2'h0);
						end
						2'h1:
						begin
							if (idx_ok)
								regs[ridx] <= byte_in;
							if (idx_ok && cfg_hit && regs[ridx] != byte_in && regs[REG_STATUS][STATUS_AUTO_CALIBRATION_ENABLE_BIT])
							begin
								cal_req <= 1'b1;
								cal_cmd <= CMD_FULL_SELF;
							end
							phase <= 2'h0;
						end
						2'h2:
							phase <= 2'h0;
						default:
							phase <= 2'h0;
					endcase
				end
			end
			if (cal_done_tick && (state == CS_OFFSET))
			begin
				if (!self_mode)
					{regs[REG_OFC0+2], regs[REG_OFC0+1], regs[REG_OFC0]} <= ain_s2;
				else
					{regs[REG_OFC0+2], regs[REG_OFC0+1], regs[REG_OFC0]} <= OFC_RST;
			end
			// System gain accepted only at or above threshold
			if (cal_done_tick && state == CS_GAIN
				&& (self_mode || 64'(ain_s2) * 100 >= 64'(GAIN_MIN_PCT) * 64'(24'h7fffff)))
				{regs[REG_FSC0+2], regs[REG_FSC0+1], regs[REG_FSC0]} <= self_mode ? FSC_RST : ain_s2;
		end
	end
	// Calibration sequencer
	always_comb
	begin
		next_state = state;
		unique case (state)
			CS_IDLE:
				if (cal_req)
					next_state = (cal_cmd == CMD_SELF_GAIN || cal_cmd == CMD_SYS_GAIN) ? CS_GAIN : CS_OFFSET;
			CS_OFFSET:
				if (cal_done_tick)
					next_state = offset_only ? CS_SETTLE : CS_GAIN;
			CS_GAIN:
				if (cal_done_tick)
					next_state = CS_SETTLE;
			CS_SETTLE:
				if (cal_done_tick)
					next_state = CS_IDLE;
			default:
				next_state = CS_IDLE;
		endcase
	end
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= CS_IDLE;
			cal_cnt <= 32'h0;
			self_mode <= 1'b0;
			offset_only <= 1'b0;
			gain_only <= 1'b0;
			link.data_ready_n <= 1'b1;
			link.ain_attached <= 1'b1;
		end
		else
		begin
			state <= next_state;
			if (cal_cnt != 32'h0)
				cal_cnt <= cal_cnt - 32'h1;
			if (state == CS_IDLE && cal_req)
			begin
				self_mode <= cal_cmd == CMD_FULL_SELF || cal_cmd == CMD_SELF_OFFSET || cal_cmd == CMD_SELF_GAIN;
				offset_only <= cal_cmd == CMD_SELF_OFFSET || cal_cmd == CMD_SYS_OFFSET;
				gain_only <= cal_cmd == CMD_SELF_GAIN || cal_cmd == CMD_SYS_GAIN;
				// Same offset time for self and system
				cal_cnt <= (cal_cmd == CMD_SELF_GAIN || cal_cmd == CMD_SYS_GAIN) ? gain_time : 32'(OFFSET_CYC);
				link.data_ready_n <= 1'b1;
				link.ain_attached <= !(cal_cmd == CMD_FULL_SELF || cal_cmd == CMD_SELF_OFFSET
					|| cal_cmd == CMD_SELF_GAIN);
			end
			else if (state == CS_OFFSET && cal_done_tick)
			begin
				cal_cnt <= offset_only ? 32'(SETTLE_CYC) : gain_time;
				// Reattach before settling
				if (offset_only)
					link.ain_attached <= 1'b1;
			end
			else if (state == CS_GAIN && cal_done_tick)
			begin
				cal_cnt <= 32'(SETTLE_CYC);
				link.ain_attached <= 1'b1;
			end
			else if (state == CS_SETTLE && cal_done_tick)
			begin
				link.data_ready_n <= 1'b0;
				link.ain_attached <= 1'b1;
			end
		end
	end
	assign link.dout_o = obyte[7];
	assign link.dout_oe = out_en;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cal_busy <= 1'b0;
			offset_out <= OFC_RST;
			gain_out <= FSC_RST;
		end
		else
		begin
			cal_busy <= state != CS_IDLE;
			offset_out <= {regs[REG_OFC0+2], regs[REG_OFC0+1], regs[REG_OFC0]};
			gain_out <= {regs[REG_FSC0+2], regs[REG_FSC0+1], regs[REG_FSC0]};
		end
	end
endmodule

// >>> src/cal_host.sv
module cal_host
	import cal_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Link
	cal_link_if.host link,
	// Command bytes in
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic tx_last,
	// Calibration stimulus value
	input wire logic [23:0] ain_value,
	// Read bytes out
	output logic [7:0] rx_data,
	output logic rx_valid,
	// Sync'd data ready
	output logic ready_n
);
	logic [1:0] data_ready_n_s, dout_s;
	logic [7:0] f_data;
	logic f_valid;
	logic f_ready;
	cal_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);
	logic [2:0] div;
	logic [7:0] sh;
	logic [7:0] rsh;
	logic [2:0] bcnt;
	logic active;
	logic sclk_r;
	logic closing;
	wire tick = div == 3'(LINK_DIV - 1);
	assign f_ready = !active && !closing;
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			data_ready_n_s <= 2'h3;
			dout_s <= 2'h0;
			div <= 3'h0;
			sh <= 8'h0;
			rsh <= 8'h0;
			bcnt <= 3'h0;
			active <= 1'b0;
			sclk_r <= 1'b0;
			closing <= 1'b0;
			rx_data <= 8'h0;
			rx_valid <= 1'b0;
			ready_n <= 1'b1;
			link.cs_n <= 1'b1;
		end
		else
		begin
			data_ready_n_s <= {data_ready_n_s[0], link.data_ready_n};
			dout_s <= {dout_s[0], link.dout_o};
			ready_n <= data_ready_n_s[1];
			rx_valid <= 1'b0;
			div <= tick ? 3'h0 : div + 3'h1;
			if (!active && !closing && f_valid)
			begin
				sh <= f_data;
				active <= 1'b1;
				link.cs_n <= 1'b0;
				bcnt <= 3'h0;
			end
			// Deselect a half period after the last fall, so the last byte is taken
			else if (closing && tick)
			begin
				closing <= 1'b0;
				link.cs_n <= 1'b1;
			end
			else if (active && tick)
			begin
				sclk_r <= !sclk_r;
				if (sclk_r)
				begin
					// Falling edge: device samples; host samples output too
					rsh <= {rsh[6:0], dout_s[1]};
					sh <= {sh[6:0], 1'b0};
					bcnt <= bcnt + 3'h1;
					if (bcnt == 3'h7)
					begin
						active <= 1'b0;
						rx_data <= {rsh[6:0], dout_s[1]};
						rx_valid <= 1'b1;
						if (tx_last)
							closing <= 1'b1;
					end
				end
			end
		end
	end
	assign link.sclk = sclk_r;
	assign link.din = sh[7];
	assign link.ain_diff = ain_value;
endmodule

// >>> test/cal_link_sva.sv
module cal_link_sva
#(
	parameter int IDLE_CYC = 200
)
(
	// System
	input wire logic clk,
	input wire logic sys_rst,
	// Link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic data_ready_n,
	input wire logic [23:0] ain_diff,
	input wire logic ain_attached
);
	int low_cnt;

	// Cycles with the link clock low, saturating
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			low_cnt <= 0;
		else if (sclk)
			low_cnt <= 0;
		else if (low_cnt < IDLE_CYC + 8)
			low_cnt <= low_cnt + 1;
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_cs_float;
		cs_n [*4] |-> !dout_oe;
	endproperty
	a_cs_float: assert property (p_cs_float) else $error("output driven while deselected");
	property p_idle;
		low_cnt >= IDLE_CYC + 4 |-> !dout_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("output driven after idle timeout");
	property p_launch;
		dout_oe && $past(dout_oe) && $changed(dout_o) |-> sclk;
	endproperty
	a_launch: assert property (p_launch) else $error("output bit changed with clock low");
	property p_oe_cs;
		$rose(dout_oe) |-> !cs_n;
	endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("output enabled without selection");
	property p_detach;
		!ain_attached |-> data_ready_n;
	endproperty
	a_detach: assert property (p_detach) else $error("inputs detached with data ready");
	property p_hold;
		$rose(data_ready_n) |=> data_ready_n [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("data ready fell too early");
	property p_bound;
		$rose(data_ready_n) |-> ##[1:1000] !data_ready_n;
	endproperty
	a_bound: assert property (p_bound) else $error("calibration did not finish");
	property p_settled;
		$fell(data_ready_n) |-> ain_attached && $past(ain_attached);
	endproperty
	a_settled: assert property (p_settled) else $error("data ready while detached");
endmodule

// >>> test/tb_top.sv
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD %s expected %0h seen %0h", n, e, a); end end
module tb_top
	import cal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OFF_C = 50;
	localparam int GAIN_C = 50;
	localparam int IDLE_C = 200;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	logic [23:0] ain_value = 24'h000000;
	logic tx_ready;
	logic [7:0] rx_data;
	logic rx_valid;
	logic [23:0] offset_out;
	logic [23:0] gain_out;
	logic [7:0] rx_seen = 8'h00;
	logic att;
	int bad_count = 0;
	int total_checks = 0;
	int t_so, t_sg, t_f, t_o, t_g, t_x;

	always #10 clk = ~clk;
	always @(posedge clk) if (rx_valid) rx_seen <= rx_data;

	cal_link_if link();
	cal_device #(.OFFSET_CYC(OFF_C), .GAIN_CYC(GAIN_C), .SETTLE_CYC(8), .IDLE_CYC(IDLE_C)) u_cal_device (
		.clk(clk), .sys_rst(sys_rst), .link(link), .cal_busy(), .offset_out(offset_out), .gain_out(gain_out));
	cal_host u_cal_host (.clk(clk), .sys_rst(sys_rst), .link(link), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_last(tx_last), .ain_value(ain_value), .rx_data(rx_data), .rx_valid(rx_valid),
		.ready_n());
	cal_link_sva #(.IDLE_CYC(IDLE_C)) u_cal_link_sva (.clk(clk), .sys_rst(sys_rst), .cs_n(link.cs_n),
		.sclk(link.sclk), .din(link.din), .dout_o(link.dout_o), .dout_oe(link.dout_oe),
		.data_ready_n(link.data_ready_n), .ain_diff(link.ain_diff), .ain_attached(link.ain_attached));

	task automatic complete_run();
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic guard(input bit hit);
		if (hit)
		begin
			`CHK("wait", 1'b0, 1'b1)
			complete_run();
		end
	endtask

	// Hands one byte to the host queue; valid stays up
	task automatic push(input logic [7:0] b);
		int n;
		n = 0;
		tx_data = b;
		tx_valid = 1'b1;
		@(posedge clk);
		while (tx_ready !== 1'b1 && n < 100)
		begin
			n++;
			@(posedge clk);
		end
		#1;
		guard(n >= 100);
	endtask

	// Whole transaction; last raised mid final byte; no continuous read
	task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input int nb);
		int n;
		int falls;
		logic prev;
		n = 0;
		falls = 0;
		@(posedge clk);
		#1;
		push(b0);
		if (nb == 2)
			push(b1);
		tx_valid = 1'b0;
		prev = link.sclk;
		while (falls < 8 * nb - 4 && n < 5000)
		begin
			@(posedge clk);
			n++;
			if (prev && !link.sclk)
				falls++;
			prev = link.sclk;
		end
		#1 tx_last = 1'b1;
		while (link.cs_n !== 1'b1 && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		#1 tx_last = 1'b0;
		guard(n >= 5000);
	endtask

	task automatic settle(inout int t);
		while (link.data_ready_n !== 1'b0 && t < 3000)
		begin
			@(posedge clk);
			t++;
		end
		#1;
		guard(t >= 3000);
	endtask

	task automatic cal(input logic [7:0] cmd, input logic [23:0] ain, output int t, output logic a);
		ain_value = ain;
		xfer(cmd, 8'h00, 1);
		`CHK("ready_high", 1'b1, link.data_ready_n)
		repeat (10) @(posedge clk);
		a = link.ain_attached;
		t = 10;
		settle(t);
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		#1 sys_rst = 1'b0;
		`CHK("offset_rst", OFC_RST, offset_out)
		`CHK("gain_rst", FSC_RST, gain_out)
		`CHK("oe_rst", 1'b0, link.dout_oe)
		cal(CMD_SYS_OFFSET, 24'h000123, t_so, att);
		`CHK("sys_offset", 24'h000123, offset_out)
		`CHK("attached_sys", 1'b1, att)
		cal(CMD_SYS_GAIN, 24'h666665, t_x, att);
		`CHK("gain_reject", FSC_RST, gain_out)
		cal(CMD_SYS_GAIN, 24'h666666, t_sg, att);
		`CHK("gain_accept", 24'h666666, gain_out)
		cal(CMD_FULL_SELF, 24'h000123, t_f, att);
		`CHK("self_offset", OFC_RST, offset_out)
		`CHK("self_gain", FSC_RST, gain_out)
		`CHK("attached_self", 1'b0, att)
		cal(CMD_SELF_OFFSET, 24'h000000, t_o, att);
		`CHK("offset_time", t_o, t_so)
		`CHK("full_time", t_o + GAIN_C, t_f)
		cal(CMD_SELF_GAIN, 24'h000000, t_g, att);
		`CHK("gain_time", t_g, t_sg)
		xfer(CMD_WRITE_REG | {4'h0, REG_OFC0}, 8'h77, 2);
		`CHK("offset_write", 24'h000077, offset_out)
		xfer(CMD_READ_REG | {4'h0, REG_OFC0}, 8'h00, 2);
		`CHK("offset_read", 8'h77, rx_seen)
		xfer(CMD_READ_REG | {4'h0, REG_FSC0 + 4'h2}, 8'h00, 2);
		`CHK("gain_read", FSC_RST[23:16], rx_seen)
		xfer(CMD_WRITE_REG | {4'h0, REG_STATUS}, 8'h04, 2);
		`CHK("no_autocal", 1'b0, link.data_ready_n)
		xfer(CMD_WRITE_REG | {4'h0, REG_RATE}, 8'h10, 2);
		`CHK("autocal", 1'b1, link.data_ready_n)
		t_x = 0;
		settle(t_x);
		`CHK("autocal_offset", OFC_RST, offset_out)
		complete_run();
	end
endmodule
